// [rtl/pidl_bcd_dec.sv]
`timescale 1ns/1ps
module pidl_bcd_dec (
	input wire logic [15:0] bcd_in, // four bcd digits xx.xx
	output logic [13:0] bin_out // value in hundredths
);
	import pidl_pkg::*;
	// digit weights 1000, 100, 10, 1
	wire logic [13:0] dig3 = {10'h000, bcd_in[15:12]};
	wire logic [13:0] dig2 = {10'h000, bcd_in[11:8]};
	wire logic [13:0] dig1 = {10'h000, bcd_in[7:4]};
	wire logic [13:0] dig0 = {10'h000, bcd_in[3:0]};
	assign bin_out = dig3 * 14'h03E8 + dig2 * 14'h0064 + dig1 * 14'h000A
		+ dig0; // RL1
endmodule // pidl_bcd_dec

// [rtl/pidl_loop.sv]
// Function
// RL1: gains are four bcd digits, read as 00.00 to 99.99
// RL2: proportional gain 0000 drops the proportional term
// RL3: integral gain 0000 or 9999 drops the integrator term
// RL4: integral time in seconds or minutes, derivative in seconds
// RL5: derivative gain 0000 drops the derivative term
// RL6: derivative term capped by a limit of 0 to 20 when enabled
// RL7: error is setpoint minus process value, fed to all three terms
// RL8: output is proportional plus integral plus derivative sum
// RL9: squared error keeps the original sign
// RL10: deadband replaces small errors with zero
// RL11: freeze bias stops integrating while output sits at range end
// RL12: freeze bias enable is bit 10 of mode word one
// RL13: freeze point is data range end, not user output limits
// RL14: output clamped to lower and upper limits, upper resets to 0
// RL15: setpoint limiting restricts setpoint to programmed bounds
// RL16: auto-transferred process value passes a first-order filter
// RL17: cascade minor loop takes setpoint from major loop output
// RL18: output auto-transfer claims all analog output channels
// RL19: control output stored at table word 5
// RL20: manual mode skips the calculation and leaves output alone
// RL21: mode bit 15 clear forces manual while program is halted
// RL22: term sums saturate at data range before output limiting
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module pidl_loop #(
	parameter int SAMPLE_MS = 100 // loop sample time in ms
) (
	input wire logic clock, // 40 MHz
	input wire logic rst, // synchronous, active high
	input wire logic ce, // clock enable
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [15:0] pv_in, // analog input module word
	input wire logic [15:0] major_cv, // major loop control output
	input wire logic program_halted, // ladder program halted
	output logic [15:0] ao_data, // analog output word
	output logic [3:0] ao_chan_claim, // channels held by the loop
	output logic cv_update // pulse on new control output
);
	import pidl_pkg::*;
	localparam int SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;

	function automatic logic signed [31:0] ext(input logic [15:0] v);
		return $signed({16'h0000, v});
	endfunction

	function automatic logic [15:0] clamp(input logic signed [31:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		logic signed [31:0] r;
		r = (v > ext(hi)) ? ext(hi) : v;
		r = (r < ext(lo)) ? ext(lo) : r;
		return r[15:0];
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [15:0] mode1_reg, mode2_reg, sp_reg, pv_reg, bias_reg, cv_reg;
	logic [15:0] kp_reg, ki_reg, kd_reg, olo_reg, ohi_reg, splo_reg;
	logic [15:0] sphi_reg, dlim_reg, filt_reg, db_reg, sum_reg;
	logic [15:0] bias_cand_reg, pv_s1_reg, pv_s2_reg, ao_data_reg;
	logic signed [31:0] err_reg, errp_reg;
	logic [31:0] tick_cnt_reg, rdata_reg, rd_mux;
	logic [3:0] claim_reg;
	logic ack_reg, cv_upd_reg, frozen_reg;
	pidl_state_t st_reg;
	logic [13:0] kp_bin, ki_bin, kd_bin;

	// gain decoding
	pidl_bcd_dec u_kp (.bcd_in(kp_reg), .bin_out(kp_bin));
	pidl_bcd_dec u_ki (.bcd_in(ki_reg), .bin_out(ki_bin));
	pidl_bcd_dec u_kd (.bcd_in(kd_reg), .bin_out(kd_bin));

	// mode decode
	wire pidl_opt_t opt = pidl_opt_t'(mode2_reg[7:0]);
	wire logic [1:0] mode_f = mode1_reg[MODE1_MODE_LSB +: 2];
	wire logic halt_manual = program_halted & ~mode1_reg[MODE1_INDEP_BIT];
	wire logic auto_run = (mode_f != MODE_MANUAL) & ~halt_manual; // RL20 RL21
	wire logic cascade = (mode_f == MODE_CASCADE);
	wire logic freeze_en = mode1_reg[MODE1_FREEZE_BIT]; // RL12

	// bus decode
	wire logic bus_req = avs_read | avs_write;
	wire logic [5:0] idx = avs_address[7:2];
	wire logic wr_fire = avs_write & ack_reg & ce;
	wire logic [15:0] wd = merge(16'h0000, avs_writedata, avs_byteenable);
	wire logic sw_wr_cv = wr_fire & (idx == IDX_CTRL_OUT) & ~auto_run;
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign avs_readdata = rdata_reg;

	// setpoint source and limiting
	wire logic [15:0] sp_src = cascade ? major_cv : sp_reg; // RL17
	wire logic [15:0] sp_eff = opt.sp_lim ?
		clamp(ext(sp_src), splo_reg, sphi_reg) : sp_src; // RL15

	// error shaping
	wire logic signed [31:0] e_raw = ext(sp_eff) - ext(pv_reg); // RL7
	wire logic signed [31:0] e_mag = (e_raw < 0) ? -e_raw : e_raw;
	wire logic signed [31:0] e_sq = (e_mag * e_mag) / ext(RANGE_MAX);
	wire logic signed [31:0] e_shp = opt.squared ?
		((e_raw < 0) ? -e_sq : e_sq) : e_raw; // RL9
	wire logic signed [31:0] e_sel = (opt.deadband && e_mag <= ext(db_reg))
		? 32'sh0 : e_shp; // RL10

	// proportional term
	wire logic signed [31:0] kp_s = $signed({18'h00000, kp_bin});
	wire logic signed [31:0] p_term = (kp_reg == GAIN_OFF_BCD) ? 32'sh0
		: (kp_s * err_reg) / GAIN_SCALE; // RL1 RL2

	// integral step, time base in seconds or minutes
	wire logic i_off = (ki_reg == GAIN_OFF_BCD) || (ki_reg == KI_INF_BCD);
	wire logic signed [31:0] i_div = $signed({18'h00000, ki_bin})
		* MS_PER_HUNDREDTH * (opt.i_minutes ? SEC_PER_MIN : 1); // RL4
	wire logic signed [31:0] i_step = i_off ? 32'sh0
		: (err_reg * SAMPLE_MS) / i_div; // RL3

	// derivative term in seconds with optional cap
	wire logic signed [31:0] kd_s = $signed({18'h00000, kd_bin});
	wire logic signed [31:0] d_raw = (kd_reg == GAIN_OFF_BCD) ? 32'sh0
		: (kd_s * (err_reg - errp_reg) * MS_PER_HUNDREDTH)
		/ SAMPLE_MS; // RL4 RL5
	wire logic [15:0] dlim_eff = (dlim_reg > DLIM_MAX) ? DLIM_MAX : dlim_reg;
	wire logic signed [31:0] d_cap = ext(dlim_eff) * DLIM_STEP;
	wire logic signed [31:0] d_term = !opt.dlim_en ? d_raw
		: (d_raw > d_cap) ? d_cap
		: (d_raw < -d_cap) ? -d_cap : d_raw; // RL6

	// sums saturate at the data range
	wire logic [15:0] sum_sat = clamp(p_term + ext(bias_reg) + d_term,
		RANGE_MIN, RANGE_MAX); // RL8 RL22
	wire logic [15:0] bias_sat = clamp(ext(bias_reg) + i_step,
		RANGE_MIN, RANGE_MAX); // RL22
	wire logic at_end = (sum_reg == RANGE_MIN) || (sum_reg == RANGE_MAX);
	wire logic freeze_now = freeze_en & at_end; // RL11 RL13
	wire logic [15:0] cv_next = clamp(ext(sum_reg), olo_reg, ohi_reg);

	// process value filter
	wire logic signed [31:0] pv_diff = ext(pv_s2_reg) - ext(pv_reg);
	wire logic signed [31:0] pv_filt = ext(pv_reg)
		+ ((pv_diff * ext(filt_reg)) >>> FILT_SHIFT);
	wire logic [15:0] pv_new = (opt.filt_en && filt_reg != RST_WORD)
		? pv_filt[15:0] : pv_s2_reg; // RL16
	wire logic tick = (tick_cnt_reg == 32'h0);
	wire logic pv_load = ce & tick & opt.pv_auto & (st_reg == ST_WAIT);
	wire logic store = ce & (st_reg == ST_STORE);

	// read decode
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (idx == IDX_MODE1) rd_mux[15:0] = mode1_reg;
		else if (idx == IDX_MODE2) rd_mux[15:0] = mode2_reg;
		else if (idx == IDX_SETPT) rd_mux[15:0] = sp_reg;
		else if (idx == IDX_PROC) rd_mux[15:0] = pv_reg;
		else if (idx == IDX_BIAS) rd_mux[15:0] = bias_reg;
		else if (idx == IDX_CTRL_OUT) rd_mux[15:0] = cv_reg; // RL19
		else if (idx == IDX_KP) rd_mux[15:0] = kp_reg;
		else if (idx == IDX_KI) rd_mux[15:0] = ki_reg;
		else if (idx == IDX_KD) rd_mux[15:0] = kd_reg;
		else if (idx == IDX_OUT_LO) rd_mux[15:0] = olo_reg;
		else if (idx == IDX_OUT_HI) rd_mux[15:0] = ohi_reg;
		else if (idx == IDX_SP_LO) rd_mux[15:0] = splo_reg;
		else if (idx == IDX_SP_HI) rd_mux[15:0] = sphi_reg;
		else if (idx == IDX_DLIM) rd_mux[15:0] = dlim_reg;
		else if (idx == IDX_FILT) rd_mux[15:0] = filt_reg;
		else if (idx == IDX_DBAND) rd_mux[15:0] = db_reg;
		else if (idx == IDX_STATUS)
			rd_mux[3:0] = {st_reg, auto_run, frozen_reg};
	end

	// bus handshake, answer one cycle after the request
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else if (ce)
		begin
			ack_reg <= bus_req & ~ack_reg;
			if (avs_read & ~ack_reg)
				rdata_reg <= rd_mux;
		end
	end

	// configuration words written by software
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode1_reg <= RST_WORD;
			mode2_reg <= RST_WORD;
			kp_reg <= RST_WORD;
			ki_reg <= RST_WORD;
			kd_reg <= RST_WORD;
			olo_reg <= RST_WORD;
			ohi_reg <= RST_WORD; // RL14
			splo_reg <= RST_WORD;
			sphi_reg <= RST_WORD;
			dlim_reg <= RST_WORD;
			filt_reg <= RST_WORD;
			db_reg <= RST_WORD;
		end
		else if (wr_fire)
		begin
			if (idx == IDX_MODE1) mode1_reg <= merge(mode1_reg, avs_writedata,
				avs_byteenable);
			if (idx == IDX_MODE2) mode2_reg <= merge(mode2_reg, avs_writedata,
				avs_byteenable);
			if (idx == IDX_KP) kp_reg <= merge(kp_reg, avs_writedata,
				avs_byteenable);
			if (idx == IDX_KI) ki_reg <= merge(ki_reg, avs_writedata,
				avs_byteenable);
			if (idx == IDX_KD) kd_reg <= merge(kd_reg, avs_writedata,
				avs_byteenable);
			if (idx == IDX_OUT_LO) olo_reg <= wd;
			if (idx == IDX_OUT_HI) ohi_reg <= wd;
			if (idx == IDX_SP_LO) splo_reg <= wd;
			if (idx == IDX_SP_HI) sphi_reg <= wd;
			if (idx == IDX_DLIM) dlim_reg <= wd;
			if (idx == IDX_FILT) filt_reg <= wd;
			if (idx == IDX_DBAND) db_reg <= wd;
		end
	end

	// loop data words, hardware update wins over software
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sp_reg <= RST_WORD;
			pv_reg <= RST_WORD;
			bias_reg <= RST_WORD;
			cv_reg <= RST_WORD;
		end
		else
		begin
			if (wr_fire && idx == IDX_SETPT)
				sp_reg <= opt.sp_lim ? clamp(ext(wd), splo_reg, sphi_reg)
					: wd; // RL15
			if (pv_load)
				pv_reg <= pv_new; // RL16
			else if (wr_fire && idx == IDX_PROC)
				pv_reg <= wd;
			if (store && !freeze_now)
				bias_reg <= bias_cand_reg; // RL11
			else if (wr_fire && idx == IDX_BIAS)
				bias_reg <= wd;
			if (store)
				cv_reg <= cv_next; // RL14 RL19
			else if (sw_wr_cv)
				cv_reg <= wd; // RL20
		end
	end

	// loop sequencer
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_reg <= ST_WAIT;
			tick_cnt_reg <= 32'h0;
			err_reg <= 32'sh0;
			errp_reg <= 32'sh0;
			sum_reg <= RST_WORD;
			bias_cand_reg <= RST_WORD;
			frozen_reg <= 1'b0;
			cv_upd_reg <= 1'b0;
		end
		else if (ce)
		begin
			tick_cnt_reg <= tick ? 32'(SAMPLE_CYC - 1) : tick_cnt_reg - 32'h1;
			cv_upd_reg <= (st_reg == ST_STORE);
			case (st_reg)
				ST_WAIT:
					if (tick && auto_run) st_reg <= ST_ERR; // RL20
				ST_ERR:
				begin
					err_reg <= e_sel; // RL7
					st_reg <= ST_TERMS;
				end
				ST_TERMS:
				begin
					sum_reg <= sum_sat; // RL8
					bias_cand_reg <= bias_sat;
					st_reg <= ST_STORE;
				end
				default:
				begin
					errp_reg <= err_reg;
					frozen_reg <= freeze_now;
					st_reg <= ST_WAIT;
				end
			endcase
		end
	end

	// analog input sync and analog output transfer
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pv_s1_reg <= RST_WORD;
			pv_s2_reg <= RST_WORD;
			ao_data_reg <= RST_WORD;
			claim_reg <= 4'h0;
		end
		else if (ce)
		begin
			pv_s1_reg <= pv_in;
			pv_s2_reg <= pv_s1_reg;
			ao_data_reg <= opt.out_auto ? cv_reg : RST_WORD;
			claim_reg <= {4{opt.out_auto}}; // RL18
		end
	end
	assign ao_data = ao_data_reg;
	assign ao_chan_claim = claim_reg;
	assign cv_update = cv_upd_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_manual_holds_cv: assert property ( // RL20
		(!auto_run && !sw_wr_cv && st_reg == ST_WAIT) |=> $stable(cv_reg))
		else $error("control output changed in manual mode");
	a_halt_manual: assert property ( // RL21
		(program_halted && !mode1_reg[MODE1_INDEP_BIT]
		&& st_reg == ST_WAIT) |=> (st_reg == ST_WAIT))
		else $error("halt did not force manual mode");
	a_pterm_off: assert property ( // RL2
		(st_reg == ST_TERMS && ce && kp_reg == GAIN_OFF_BCD && d_term == 0
		&& !wr_fire && bias_reg <= RANGE_MAX) |=> (sum_reg == bias_reg))
		else $error("proportional term not removed");
	a_iterm_off: assert property ( // RL3
		(ki_reg == KI_INF_BCD || ki_reg == GAIN_OFF_BCD) |-> (i_step == 0))
		else $error("integrator term not removed");
	a_dterm_off: assert property ( // RL5
		(kd_reg == GAIN_OFF_BCD) |-> (d_term == 0))
		else $error("derivative term not removed");
	a_dlim_cap: assert property ( // RL6
		opt.dlim_en |-> (d_term <= d_cap && d_term >= -d_cap))
		else $error("derivative term above cap");
	a_deadband_zero: assert property ( // RL10
		(st_reg == ST_ERR && ce && opt.deadband && e_mag <= ext(db_reg))
		|=> (err_reg == 0))
		else $error("deadband error not zero");
	a_freeze_bias: assert property ( // RL11
		(store && freeze_en && (sum_reg == RANGE_MAX || sum_reg == RANGE_MIN)
		&& !(wr_fire && idx == IDX_BIAS)) |=> $stable(bias_reg))
		else $error("bias moved while frozen");
	a_cv_limits: assert property ( // RL14
		(st_reg == ST_TERMS && ce && olo_reg <= ohi_reg && !wr_fire)
		|=> ##1 (cv_reg <= ohi_reg && cv_reg >= olo_reg))
		else $error("control output outside limits");
	a_bus_answer: assert property (
		(bus_req && ce && !ack_reg) |=> (!avs_waitrequest || !bus_req))
		else $error("bus answer late");
endmodule // pidl_loop

// [rtl/pidl_pkg.sv]
package pidl_pkg;
	// clock rate
	localparam int CLK_KHZ = 40000;
	localparam int MS_PER_HUNDREDTH = 10;
	localparam int SEC_PER_MIN = 60;
	// loop table word indexes, byte address is four times the index
	localparam logic [5:0] IDX_MODE1 = 6'h00;
	localparam logic [5:0] IDX_MODE2 = 6'h01;
	localparam logic [5:0] IDX_SETPT = 6'h02;
	localparam logic [5:0] IDX_PROC = 6'h03;
	localparam logic [5:0] IDX_BIAS = 6'h04;
	localparam logic [5:0] IDX_CTRL_OUT = 6'h05;
	localparam logic [5:0] IDX_KP = 6'h06;
	localparam logic [5:0] IDX_KI = 6'h07;
	localparam logic [5:0] IDX_KD = 6'h08;
	localparam logic [5:0] IDX_OUT_LO = 6'h09;
	localparam logic [5:0] IDX_OUT_HI = 6'h0A;
	localparam logic [5:0] IDX_SP_LO = 6'h0B;
	localparam logic [5:0] IDX_SP_HI = 6'h0C;
	localparam logic [5:0] IDX_DLIM = 6'h0D;
	localparam logic [5:0] IDX_FILT = 6'h0E;
	localparam logic [5:0] IDX_DBAND = 6'h0F;
	localparam logic [5:0] IDX_STATUS = 6'h10;
	// mode word one fields
	localparam int MODE1_MODE_LSB = 0;
	localparam int MODE1_FREEZE_BIT = 10;
	localparam int MODE1_INDEP_BIT = 15;
	// reset value of every table word
	localparam logic [15:0] RST_WORD = 16'h0000;
	// unipolar 12-bit data range
	localparam logic [15:0] RANGE_MIN = 16'h0000;
	localparam logic [15:0] RANGE_MAX = 16'h0FFF;
	// gain coding
	localparam int GAIN_SCALE = 100;
	localparam logic [15:0] KI_INF_BCD = 16'h9999;
	localparam logic [15:0] GAIN_OFF_BCD = 16'h0000;
	// derivative limit
	localparam logic [15:0] DLIM_MAX = 16'h0014;
	localparam int DLIM_STEP = 205;
	// filter coefficient is a fraction of 256
	localparam int FILT_SHIFT = 8;

	typedef enum logic [1:0] {
		MODE_MANUAL = 2'h0,
		MODE_AUTO = 2'h1,
		MODE_CASCADE = 2'h2
	} pidl_mode_t;

	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_ERR = 2'b01,
		ST_TERMS = 2'b11,
		ST_STORE = 2'b10
	} pidl_state_t;

	// mode word two, bits 7..0
	typedef struct packed {
		logic out_auto;
		logic pv_auto;
		logic i_minutes;
		logic filt_en;
		logic sp_lim;
		logic dlim_en;
		logic deadband;
		logic squared;
	} pidl_opt_t;
endpackage

// [test/pidl_io_model.sv]
`timescale 1ns/1ps
module pidl_io_model (
	input wire logic clock, // loop clock
	input wire logic rst, // synchronous reset
	input wire logic halt_req, // bench asks for a halted program
	input wire logic [15:0] ao_data, // word sent to the output module
	input wire logic [3:0] ao_chan_claim, // channels taken by the loop
	output logic [15:0] pv_in, // input module sample
	output logic [15:0] major_cv, // major loop control output
	output logic program_halted, // program stopped
	output logic [15:0] ao_seen // last word the output module took
);
	logic [11:0] ramp_reg;
	// input module converts a slowly rising signal
	always_ff @(posedge clock)
	begin
		if (rst)
			ramp_reg <= 12'h000;
		else
			ramp_reg <= ramp_reg + 12'h001;
	end
	// unipolar 12-bit words from the modules
	assign pv_in = {4'h0, ramp_reg};
	assign major_cv = 16'h0800;
	// program run state follows the request one cycle later
	always_ff @(posedge clock)
	begin
		program_halted <= rst ? 1'b0 : halt_req;
	end
	// output module latches only with every channel held by loops
	always_ff @(posedge clock)
	begin
		if (rst)
			ao_seen <= 16'h0000;
		else if (ao_chan_claim == 4'hF)
			ao_seen <= ao_data;
	end
endmodule // pidl_io_model

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import pidl_pkg::*;
	localparam int SIM_MS = 1;
	localparam int TICK_CYC = SIM_MS * CLK_KHZ;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] pv_in;
	logic [15:0] major_cv;
	logic program_halted;
	logic halt_req = 1'b0;
	logic [15:0] ao_data;
	logic [3:0] ao_chan_claim;
	logic cv_update;
	logic [15:0] ao_seen;
	int n_fail = 0;
	int compares = 0;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	pidl_loop #(.SAMPLE_MS(SIM_MS)) dut (
		.clock(clock), .rst(rst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pv_in(pv_in),
		.major_cv(major_cv), .program_halted(program_halted),
		.ao_data(ao_data), .ao_chan_claim(ao_chan_claim),
		.cv_update(cv_update)
	);

	pidl_io_model io_model (
		.clock(clock), .rst(rst), .halt_req(halt_req),
		.ao_data(ao_data), .ao_chan_claim(ao_chan_claim),
		.pv_in(pv_in), .major_cv(major_cv),
		.program_halted(program_halted), .ao_seen(ao_seen)
	);

	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d failures %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// compare one word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus_cycle(input logic is_wr, input logic [5:0] idx,
		input logic [15:0] wdata, output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {16'h0000, wdata};
		avs_byteenable <= 4'h3;
		avs_write <= is_wr;
		avs_read <= ~is_wr;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100)
			chk(32'h0, 32'h1, "bus answer missing");
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		logic [31:0] junk;
		bus_cycle(1'b1, idx, d, junk);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
		logic [31:0] got;
		bus_cycle(1'b0, idx, 16'h0000, got);
		chk(got, {16'h0000, exp}, "register read");
	endtask

	// wait for a finished loop calculation
	task automatic wait_tick();
		int n;
		n = 0;
		while (cv_update !== 1'b1 && n < TICK_CYC + 5000)
		begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, cv_update}, 32'h1, "no loop update");
		repeat (3) @(posedge clock);
	endtask

	// watchdog
	initial
	begin
		#(TICK_CYC * 25 * 5 / 2);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end

	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// reset values and an unmapped word
		rd_chk(IDX_MODE1, RST_WORD);
		rd_chk(IDX_CTRL_OUT, RST_WORD);
		rd_chk(IDX_OUT_HI, 16'h0000);
		wr(6'h20, 16'hA5A5);
		rd_chk(6'h20, 16'h0000);
		$display("test reset_values done");
		// auto loop, proportional only, output to the module
		wr(IDX_MODE1, 16'h8401);
		wr(IDX_MODE2, 16'h0080);
		wr(IDX_SETPT, 16'h03E8);
		wr(IDX_PROC, 16'h0190);
		wr(IDX_KP, 16'h0100);
		wr(IDX_KI, KI_INF_BCD);
		wr(IDX_KD, GAIN_OFF_BCD);
		wr(IDX_OUT_HI, RANGE_MAX);
		rd_chk(IDX_KP, 16'h0100);
		wr(IDX_CTRL_OUT, 16'h0123);
		rd_chk(IDX_CTRL_OUT, 16'h0000);
		wait_tick();
		rd_chk(IDX_CTRL_OUT, 16'h0258);
		chk({16'h0000, ao_data}, 32'h00000258, "ao word");
		chk({28'h0, ao_chan_claim}, 32'h0000000F, "claim");
		chk({16'h0000, ao_seen}, 32'h00000258, "module word");
		$display("test proportional_sum done");
		// proportional removed, lower limit holds the output
		wr(IDX_KP, GAIN_OFF_BCD);
		wr(IDX_OUT_LO, 16'h00C8);
		wr(IDX_MODE2, 16'h0086);
		wr(IDX_DBAND, 16'h0258);
		wait_tick();
		rd_chk(IDX_CTRL_OUT, 16'h00C8);
		$display("test lower_limit done");
		// setpoint limiting on software writes
		wr(IDX_MODE2, 16'h0008);
		wr(IDX_SP_LO, 16'h0064);
		wr(IDX_SP_HI, 16'h0320);
		wr(IDX_SETPT, 16'h0FFF);
		rd_chk(IDX_SETPT, 16'h0320);
		wr(IDX_SETPT, 16'h0010);
		rd_chk(IDX_SETPT, 16'h0064);
		wr(IDX_SETPT, 16'h0200);
		rd_chk(IDX_SETPT, 16'h0200);
		$display("test setpoint_limits done");
		// halted program with loops following it: manual, word writable
		wr(IDX_MODE1, 16'h0401);
		halt_req <= 1'b1;
		repeat (3) @(posedge clock);
		wr(IDX_CTRL_OUT, 16'h0123);
		rd_chk(IDX_CTRL_OUT, 16'h0123);
		rd_chk(IDX_STATUS, 16'h0001);
		// loops independent of the program keep running while halted
		wr(IDX_MODE1, 16'h8401);
		rd_chk(IDX_STATUS, 16'h0003);
		wr(IDX_CTRL_OUT, 16'h0456);
		rd_chk(IDX_CTRL_OUT, 16'h0123);
		$display("test halted_manual done");
		// reset in mid-run returns the table to its reset values
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd_chk(IDX_MODE1, RST_WORD);
		rd_chk(IDX_STATUS, 16'h0000);
		rd_chk(IDX_OUT_HI, RST_WORD);
		chk({28'h0, ao_chan_claim}, 32'h00000000, "claim reset");
		$display("test mid_reset done");
		wrap_up();
	end
endmodule // tb_top
